// ===== logic/gp0_pkg.sv
package gp0_pkg;

    localparam int NPINS = 8;
    localparam int ADR_W = 8;

    // Byte addresses of the port registers
    localparam logic [7:0] OFF_DATA = 8'h00;
    localparam logic [7:0] OFF_DIR = 8'h04;
    localparam logic [7:0] OFF_PUL = 8'h08;
    localparam logic [7:0] OFF_AIDL = 8'h0C;
    localparam logic [7:0] OFF_AIDH = 8'h10;
    localparam logic [7:0] OFF_CTRL = 8'h14;

    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [23:0] PAD_ZERO = 24'h000000;
    localparam logic [31:0] UNMAPPED_DATA = 32'h00000000;

    // Control register field
    localparam int CTRL_STBY_BIT = 0;

    // Pin roles for comparator functions
    localparam int PIN_CMP_A_POS = 0;
    localparam int PIN_CMP_A_NEG = 1;
    localparam int PIN_CMP_A_OUT = 2;
    localparam int PIN_CMP_B_POS = 3;
    localparam int PIN_CMP_B_NEG = 4;
    localparam int PIN_CMP_B_OUT = 5;

    typedef enum logic [6:0] {
        RS_DATA = 7'h01,
        RS_DIR = 7'h02,
        RS_PUL = 7'h04,
        RS_AIDL = 7'h08,
        RS_AIDH = 7'h10,
        RS_CTRL = 7'h20,
        RS_NONE = 7'h40
    } gp0_reg_t;

    typedef enum logic [1:0] {
        BS_IDLE = 2'h1,
        BS_ACK = 2'h2
    } gp0_bus_t;

    // Byte address decode, shared by write strobes and read mux
    function automatic gp0_reg_t gp0_decode(input logic [ADR_W-1:0] adr);
        gp0_reg_t r;
        r = RS_NONE;
        unique case (adr)
            OFF_DATA: r = RS_DATA;
            OFF_DIR: r = RS_DIR;
            OFF_PUL: r = RS_PUL;
            OFF_AIDL: r = RS_AIDL;
            OFF_AIDH: r = RS_AIDH;
            OFF_CTRL: r = RS_CTRL;
            default: r = RS_NONE;
        endcase
        return r;
    endfunction

endpackage

// ===== logic/gp0_pin_cell.sv
`timescale 1ns/1ps
// One pin: driver select, enable and pull-up control
module gp0_pin_cell (
    input wire logic latch_i,
    input wire logic dir_i,
    input wire logic pul_i,
    input wire logic periph_oe_i,
    input wire logic periph_val_i,
    input wire logic hiz_i,
    output logic pin_o,
    output logic oe_o,
    output logic pullup_o
);

    always_comb begin
        // [RQ3] [RQ16] peripheral over latch
        pin_o = periph_oe_i ? periph_val_i : latch_i;
        oe_o = (dir_i | periph_oe_i) & ~hiz_i;
        // [RQ14] pull-up drop low
        pullup_o = pul_i & ~(oe_o & ~pin_o);
    end

endmodule

// ===== logic/gp0_wb_slave.sv
`timescale 1ns/1ps
// Classic Wishbone slave front end: one wait state, registered answer
module gp0_wb_slave (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [7:0] rdata_i,
    input wire logic rd_hit_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic wr_stb_o,
    output gp0_pkg::gp0_reg_t sel_o
);

    gp0_pkg::gp0_bus_t state_q;
    logic req;

    assign req = wb_cyc_i & wb_stb_i;
    assign sel_o = gp0_pkg::gp0_decode(wb_adr_i);
    assign wb_ack_o = (state_q == gp0_pkg::BS_ACK);
    // [RQ17] write at ack edge
    assign wr_stb_o = wb_ack_o & req & wb_we_i & wb_sel_i[0];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= gp0_pkg::BS_IDLE;
        end else begin
            unique case (state_q)
                gp0_pkg::BS_IDLE: begin
                    if (req) begin
                        state_q <= gp0_pkg::BS_ACK;
                    end
                end
                gp0_pkg::BS_ACK: begin
                    state_q <= gp0_pkg::BS_IDLE;
                end
                default: begin
                    state_q <= gp0_pkg::BS_IDLE;
                end
            endcase
        end
    end

    // Read data sampled as the request is taken
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= gp0_pkg::UNMAPPED_DATA;
        end else if (state_q == gp0_pkg::BS_IDLE && req) begin
            if (rd_hit_i) begin
                wb_dat_o <= {gp0_pkg::PAD_ZERO, rdata_i};
            end else begin
                wb_dat_o <= gp0_pkg::UNMAPPED_DATA;
            end
        end
    end

endmodule

// ===== logic/gp0_port.sv
// Local design decisions: the Wishbone register port and the register offsets.
`timescale 1ns/1ps
// Behaviour
// [RQ1] Plain data read returns pin levels, 0 low and 1 high.
// [RQ2] Read-modify-write data read returns the output latch instead.
// [RQ3] Latch bit 0 or 1 drives its output pin low or high.
// [RQ4] Direction bit 0 makes input, 1 enables the pin driver.
// [RQ5] Pull-up bit 0 leaves pull-up off, 1 turns it on.
// [RQ6] Analog-disable bit 0 keeps analog use, 1 enables digital input.
// [RQ7] Register bit n serves pin n, bit0 lowest to bit7 highest.
// [RQ8] Direction, pull-up and analog-disable registers read back as written.
// [RQ9] All port registers and both analog-disable registers reset to zero.
// [RQ10] Each pin feeds its own interrupt input and analog channel.
// [RQ11] Pins 2 and 5 carry comparator outputs a and b when enabled.
// [RQ12] Pins 0,1 feed comparator a inputs; pins 3,4 comparator b.
// [RQ13] Standby select in stop or watch: pins float, inputs held low; the code holds low only pins whose ext_irq_en_i bit is 0.
// [RQ14] Pull-up disconnected from any pin driven low.
// [RQ15] Data writes always load the latch; only outputs show it.
// [RQ16] Peripheral output enable drives pin; plain read still shows level.
// [RQ17] Writes act from the completing edge, bit by bit.
module gp0_port (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic wb_lock_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [7:0] pin_i,
    output logic [7:0] pin_o,
    output logic [7:0] pin_oe_o,
    output logic [7:0] pullup_o,
    input wire logic standby_mode_i,
    input wire logic [7:0] ext_irq_en_i,
    input wire logic cmp_a_digital_out_i,
    input wire logic cmp_a_oe_i,
    input wire logic cmp_b_digital_out_i,
    input wire logic cmp_b_oe_i,
    output logic [7:0] ext_irq_in_o,
    output logic [7:0] analog_chan_o,
    output logic [7:0] analog_input_disable_high_o,
    output logic cmp_a_positive_in_o,
    output logic cmp_a_negative_in_o,
    output logic cmp_b_positive_in_o,
    output logic cmp_b_negative_in_o
);

    logic [7:0] port_data_latch_q;
    logic [7:0] port_direction_q;
    logic [7:0] port_pullup_enable_q;
    logic [7:0] analog_input_disable_low_q;
    logic [7:0] analog_input_disable_high_q;
    logic standby_pin_hiz_select_q;
    logic wr_stb;
    gp0_pkg::gp0_reg_t sel;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic rd_hit;
    logic hiz;
    logic [7:0] blocked;
    logic [7:0] pin_level;
    logic [7:0] periph_oe;
    logic [7:0] periph_val;

    assign wdata = wb_dat_i[7:0];

    gp0_wb_slave u_bus (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i),
        .rdata_i(rdata),
        .rd_hit_i(rd_hit),
        .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o),
        .wr_stb_o(wr_stb),
        .sel_o(sel)
    );

    // [RQ15] latch always loaded
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            port_data_latch_q <= gp0_pkg::RST_BYTE;
        end else if (wr_stb && sel == gp0_pkg::RS_DATA) begin
            port_data_latch_q <= wdata;
        end
    end

    // [RQ4] direction register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            port_direction_q <= gp0_pkg::RST_BYTE;
        end else if (wr_stb && sel == gp0_pkg::RS_DIR) begin
            port_direction_q <= wdata;
        end
    end

    // [RQ5] pull-up register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            port_pullup_enable_q <= gp0_pkg::RST_BYTE;
        end else if (wr_stb && sel == gp0_pkg::RS_PUL) begin
            port_pullup_enable_q <= wdata;
        end
    end

    // [RQ9] analog disable registers clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            analog_input_disable_low_q <= gp0_pkg::RST_BYTE;
            analog_input_disable_high_q <= gp0_pkg::RST_BYTE;
        end else if (wr_stb) begin
            if (sel == gp0_pkg::RS_AIDL) begin
                analog_input_disable_low_q <= wdata;
            end
            if (sel == gp0_pkg::RS_AIDH) begin
                analog_input_disable_high_q <= wdata;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            standby_pin_hiz_select_q <= 1'b0;
        end else if (wr_stb && sel == gp0_pkg::RS_CTRL) begin
            standby_pin_hiz_select_q <= wdata[gp0_pkg::CTRL_STBY_BIT];
        end
    end

    // [RQ13] standby float and input block
    assign hiz = standby_pin_hiz_select_q & standby_mode_i;
    assign blocked = {8{hiz}} & ~ext_irq_en_i;

    // [RQ6] digital input gate
    assign pin_level = pin_i & analog_input_disable_low_q & ~blocked;

    // [RQ10] interrupt and analog feeds
    assign ext_irq_in_o = pin_i & ~blocked;
    assign analog_chan_o = ~analog_input_disable_low_q;
    assign analog_input_disable_high_o = analog_input_disable_high_q;

    // [RQ12] comparator input taps
    assign cmp_a_positive_in_o = pin_i[gp0_pkg::PIN_CMP_A_POS];
    assign cmp_a_negative_in_o = pin_i[gp0_pkg::PIN_CMP_A_NEG];
    assign cmp_b_positive_in_o = pin_i[gp0_pkg::PIN_CMP_B_POS];
    assign cmp_b_negative_in_o = pin_i[gp0_pkg::PIN_CMP_B_NEG];

    // [RQ11] comparator output pins
    always_comb begin
        periph_oe = 8'h00;
        periph_val = 8'h00;
        periph_oe[gp0_pkg::PIN_CMP_A_OUT] = cmp_a_oe_i;
        periph_val[gp0_pkg::PIN_CMP_A_OUT] = cmp_a_digital_out_i;
        periph_oe[gp0_pkg::PIN_CMP_B_OUT] = cmp_b_oe_i;
        periph_val[gp0_pkg::PIN_CMP_B_OUT] = cmp_b_digital_out_i;
    end

    // [RQ7] bit n drives pin n
    for (genvar n = 0; n < gp0_pkg::NPINS; n++) begin : g_pin
        gp0_pin_cell u_cell (
            .latch_i(port_data_latch_q[n]),
            .dir_i(port_direction_q[n]),
            .pul_i(port_pullup_enable_q[n]),
            .periph_oe_i(periph_oe[n]),
            .periph_val_i(periph_val[n]),
            .hiz_i(hiz),
            .pin_o(pin_o[n]),
            .oe_o(pin_oe_o[n]),
            .pullup_o(pullup_o[n])
        );
    end

    // [RQ1] [RQ2] read mux, pin level or latch
    always_comb begin
        rdata = 8'h00;
        rd_hit = 1'b1;
        unique case (sel)
            gp0_pkg::RS_DATA: rdata = wb_lock_i ? port_data_latch_q : pin_level;
            // [RQ8] plain readback
            gp0_pkg::RS_DIR: rdata = port_direction_q;
            gp0_pkg::RS_PUL: rdata = port_pullup_enable_q;
            gp0_pkg::RS_AIDL: rdata = analog_input_disable_low_q;
            gp0_pkg::RS_AIDH: rdata = analog_input_disable_high_q;
            gp0_pkg::RS_CTRL: rdata[gp0_pkg::CTRL_STBY_BIT] = standby_pin_hiz_select_q;
            default: rd_hit = 1'b0;
        endcase
    end

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    logic req_take;
    assign req_take = wb_cyc_i & wb_stb_i & ~wb_ack_o;

    sequence seq_data_read;
        req_take && !wb_we_i && sel == gp0_pkg::RS_DATA;
    endsequence

    sequence seq_plain_read;
        seq_data_read ##0 !wb_lock_i;
    endsequence

    sequence seq_rmw_read;
        seq_data_read ##0 wb_lock_i;
    endsequence

    sequence seq_write(gp0_pkg::gp0_reg_t r);
        wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0] && sel == r;
    endsequence

    pin_read_a: assert property ( // [RQ1]
        seq_plain_read |=> wb_ack_o && wb_dat_o[7:0] == $past(pin_level)
            && wb_dat_o[31:8] == gp0_pkg::PAD_ZERO)
        else $error("plain data read did not return pin level");

    rmw_read_a: assert property ( // [RQ2]
        seq_rmw_read |=> wb_ack_o && wb_dat_o[7:0] == $past(port_data_latch_q))
        else $error("rmw data read did not return latch");

    out_level_a: assert property ( // [RQ3]
        (pin_oe_o & ~periph_oe) == (port_direction_q & ~periph_oe & ~{8{hiz}})
            && ((pin_o ^ port_data_latch_q) & ~periph_oe) == 8'h00)
        else $error("output pin does not follow latch");

    dir_enable_a: assert property ( // [RQ4]
        !hiz |-> (pin_oe_o == (port_direction_q | periph_oe)))
        else $error("driver enable disagrees with direction");

    pullup_ctl_a: assert property ( // [RQ5]
        pullup_o == (port_pullup_enable_q & ~(pin_oe_o & ~pin_o)))
        else $error("pull-up control wrong");

    analog_gate_a: assert property ( // [RQ6]
        analog_chan_o == ~analog_input_disable_low_q
            && (pin_level & ~analog_input_disable_low_q) == 8'h00)
        else $error("analog disable gating wrong");

    dir_readback_a: assert property ( // [RQ8]
        seq_write(gp0_pkg::RS_DIR) ##2 (req_take && !wb_we_i && sel == gp0_pkg::RS_DIR)
            |=> wb_dat_o[7:0] == $past(wb_dat_i[7:0], 3))
        else $error("direction readback differs from write");

    reset_zero_a: assert property ( // [RQ9]
        $past(rst_i) |-> port_data_latch_q == gp0_pkg::RST_BYTE
            && port_direction_q == gp0_pkg::RST_BYTE
            && port_pullup_enable_q == gp0_pkg::RST_BYTE
            && analog_input_disable_low_q == gp0_pkg::RST_BYTE
            && analog_input_disable_high_q == gp0_pkg::RST_BYTE)
        else $error("register not zero after reset");

    irq_feed_a: assert property ( // [RQ10]
        !hiz |-> ext_irq_in_o == pin_i)
        else $error("interrupt feed differs from pin");

    cmp_out_a: assert property ( // [RQ11]
        cmp_b_oe_i && !hiz |-> pin_oe_o[gp0_pkg::PIN_CMP_B_OUT]
            && pin_o[gp0_pkg::PIN_CMP_B_OUT] == cmp_b_digital_out_i)
        else $error("comparator output not on its pin");

    standby_hiz_a: assert property ( // [RQ13]
        standby_pin_hiz_select_q && standby_mode_i |-> pin_oe_o == 8'h00
            && (ext_irq_in_o & ~ext_irq_en_i) == 8'h00)
        else $error("standby did not float and block pins");

    latch_load_a: assert property ( // [RQ15]
        seq_write(gp0_pkg::RS_DATA) |=> port_data_latch_q == $past(wb_dat_i[7:0])
            && (pin_oe_o == $past(pin_oe_o) || $past(hiz) != hiz))
        else $error("data write did not load latch alone");

    write_edge_a: assert property ( // [RQ17]
        seq_write(gp0_pkg::RS_PUL) |=> port_pullup_enable_q == $past(wb_dat_i[7:0]))
        else $error("pull-up write not applied at ack edge");

endmodule

// ===== sim/gp0_pin_model.sv
`timescale 1ns/1ps
// External pins: device drive wins, then outside drive, then pull-up, else a drifting float
module gp0_pin_model (
    input wire logic clk_i,
    input wire logic [7:0] pin_o,
    input wire logic [7:0] pin_oe_o,
    input wire logic [7:0] pullup_o,
    input wire logic [7:0] ext_en_i,
    input wire logic [7:0] ext_val_i,
    output logic [7:0] pin_lvl_o
);
    logic [7:0] float_q = 8'h55;
    // An undriven pin without pull-up never holds a stable level
    always_ff @(posedge clk_i) begin
        float_q <= ~float_q;
    end
    assign pin_lvl_o = (pin_oe_o & pin_o) | (~pin_oe_o & ext_en_i & ext_val_i)
        | (~pin_oe_o & ~ext_en_i & (pullup_o | float_q));
endmodule

// ===== sim/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic wb_lock_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h00000000;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic [7:0] pin_i, pin_o, pin_oe_o, pullup_o, ext_irq_in_o, analog_chan_o, aid_high;
    logic standby_mode_i = 1'b0;
    logic [7:0] ext_irq_en_i = 8'h00;
    logic cmp_a_out = 1'b0;
    logic cmp_a_oe = 1'b0;
    logic cmp_b_out = 1'b0;
    logic cmp_b_oe = 1'b0;
    logic [3:0] cmp_in;
    logic [7:0] ext_en = 8'h00;
    logic [7:0] ext_val = 8'h00;
    logic [31:0] rd;
    logic [7:0] offs [6] = '{gp0_pkg::OFF_DATA, gp0_pkg::OFF_DIR, gp0_pkg::OFF_PUL,
        gp0_pkg::OFF_AIDL, gp0_pkg::OFF_AIDH, gp0_pkg::OFF_CTRL};
    int fail_count = 0;
    int n_checks = 0;

    initial begin
        forever #2 clk_i = ~clk_i;
    end

    gp0_port gp0_port_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_lock_i(wb_lock_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .pin_i(pin_i), .pin_o(pin_o), .pin_oe_o(pin_oe_o), .pullup_o(pullup_o),
        .standby_mode_i(standby_mode_i), .ext_irq_en_i(ext_irq_en_i),
        .cmp_a_digital_out_i(cmp_a_out), .cmp_a_oe_i(cmp_a_oe),
        .cmp_b_digital_out_i(cmp_b_out), .cmp_b_oe_i(cmp_b_oe),
        .ext_irq_in_o(ext_irq_in_o), .analog_chan_o(analog_chan_o),
        .analog_input_disable_high_o(aid_high), .cmp_a_positive_in_o(cmp_in[0]),
        .cmp_a_negative_in_o(cmp_in[1]), .cmp_b_positive_in_o(cmp_in[2]),
        .cmp_b_negative_in_o(cmp_in[3]));

    gp0_pin_model gp0_pin_model_inst (.clk_i(clk_i), .pin_o(pin_o), .pin_oe_o(pin_oe_o),
        .pullup_o(pullup_o), .ext_en_i(ext_en), .ext_val_i(ext_val), .pin_lvl_o(pin_i));

    task close_out;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // One classic cycle; ack and read data are taken at the rising edge that sees ack high
    task bus(input logic we, input logic lock, input logic [7:0] adr, input logic [7:0] d);
        int n;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_lock_i <= lock;
        wb_adr_i <= adr;
        wb_sel_i <= 4'h1;
        wb_dat_i <= {24'h000000, d};
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        if (wb_ack_o !== 1'b1) begin
            fail_count++;
            close_out();
        end
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
        wb_lock_i <= 1'b0;
    endtask

    task settle;
        @(posedge clk_i);
        @(negedge clk_i);
    endtask

    initial begin
        repeat (5000) @(posedge clk_i);
        fail_count++;
        close_out();
    end

    initial begin
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        settle();
        check("oe_rst", pin_oe_o, 8'h00);
        foreach (offs[i]) begin
            bus(1'b0, 1'b0, offs[i], 8'h00);
            check("reg_rst", rd, 32'h00000000);
        end
        for (int i = 1; i < 5; i++) begin
            bus(1'b1, 1'b0, offs[i], 8'hA5 ^ offs[i]);
            bus(1'b0, 1'b0, offs[i], 8'h00);
            check("readback", rd, {24'h000000, 8'hA5 ^ offs[i]});
        end
        check("analog_chan", analog_chan_o, 8'h56);
        check("aid_high", aid_high, 8'hB5);
        bus(1'b1, 1'b0, 8'h40, 8'hFF);
        bus(1'b0, 1'b0, 8'h40, 8'h00);
        check("unmapped", rd, 32'h00000000);
        // Low nibble driven from outside, high nibble by the port
        ext_en <= 8'h0F;
        ext_val <= 8'h05;
        bus(1'b1, 1'b0, gp0_pkg::OFF_DIR, 8'hF0);
        bus(1'b1, 1'b0, gp0_pkg::OFF_DATA, 8'hAA);
        bus(1'b1, 1'b0, gp0_pkg::OFF_AIDL, 8'hFF);
        bus(1'b1, 1'b0, gp0_pkg::OFF_PUL, 8'hFF);
        settle();
        check("oe", pin_oe_o, 8'hF0);
        check("drive", pin_o & pin_oe_o, 8'hA0);
        check("pullup", pullup_o, 8'hAF);
        bus(1'b0, 1'b0, gp0_pkg::OFF_DATA, 8'h00);
        check("pin_read", rd, 32'h000000A5);
        bus(1'b0, 1'b1, gp0_pkg::OFF_DATA, 8'h00);
        check("rmw_read", rd, 32'h000000AA);
        check("irq_in", ext_irq_in_o, 8'hA5);
        check("cmp_in", cmp_in, 4'h1);
        // Comparators take pins 2 and 5 over the latch
        ext_en <= 8'h0B;
        cmp_a_oe <= 1'b1;
        cmp_a_out <= 1'b1;
        cmp_b_oe <= 1'b1;
        settle();
        check("cmp_oe", pin_oe_o, 8'hF4);
        check("cmp_drive", pin_o & pin_oe_o, 8'h84);
        check("cmp_pullup", pullup_o, 8'h8F);
        bus(1'b0, 1'b0, gp0_pkg::OFF_DATA, 8'h00);
        check("cmp_read", rd, 32'h00000085);
        bus(1'b0, 1'b1, gp0_pkg::OFF_DATA, 8'h00);
        check("cmp_rmw", rd, 32'h000000AA);
        // Standby with float select: all float, unblocked interrupt inputs only
        cmp_a_oe <= 1'b0;
        cmp_b_oe <= 1'b0;
        ext_en <= 8'hFF;
        ext_val <= 8'h3C;
        ext_irq_en_i <= 8'h0F;
        bus(1'b1, 1'b0, gp0_pkg::OFF_CTRL, 8'h01);
        standby_mode_i <= 1'b1;
        settle();
        check("stby_oe", pin_oe_o, 8'h00);
        check("stby_irq", ext_irq_in_o, 8'h0C);
        bus(1'b0, 1'b0, gp0_pkg::OFF_DATA, 8'h00);
        check("stby_read", rd, 32'h0000000C);
        standby_mode_i <= 1'b0;
        settle();
        check("wake_oe", pin_oe_o, 8'hF0);
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        bus(1'b0, 1'b0, gp0_pkg::OFF_DIR, 8'h00);
        check("rerst_dir", rd, 32'h00000000);
        check("rerst_pull", pullup_o, 8'h00);
        close_out();
    end
endmodule
